/* btm_maps.sv */
// Purpose: Active node map and speed map built from self-ID packets
// Assumes: Self-ID source and bus-reset flags are on I_CLK
// Notes: Maps are read through a registered host read port
`timescale 1ns/1ps
`default_nettype none
`include "btm_map.svh"
module btm_maps (
  // Clock, reset, enable
  input wire logic I_CLK,
  input wire logic I_RST_B,
  input wire logic I_CE,
  // Bus state from link core
  input wire logic I_BUS_RESET,
  input wire logic I_SID_DONE,
  input wire logic [`BTM_NODE_W-1:0] I_OWN_NODE,
  // Self-ID quadlets
  input wire logic I_SID_VALID,
  input wire logic [31:0] I_SID_QUAD,
  // Host read port
  input wire logic I_RD,
  input wire logic [7:0] I_ADDR,
  output logic [31:0] O_RDATA,
  output logic O_RVALID
);
  localparam int NODES = `BTM_NODE_COUNT;
  // Map state
  logic [NODES-1:0] seen_r;
  logic [NODES-1:0] seen_nxt;
  logic [NODES-1:0] act_r;
  logic [NODES-1:0] act_nxt;
  logic [2*NODES-1:0] spd_r;
  logic [2*NODES-1:0] spd_nxt;
  logic done_r;
  logic done_nxt;
  // Read state
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic rvalid_r;
  logic rvalid_nxt;
  logic [NODES-1:0] act_view;
  logic [31:0] mux_data;
  btm_pkg::btm_sid_s sid;
  // =====================================================================
  // Self-ID field decode
  btm_sid_decode u_dec (
    .i_quad(I_SID_QUAD),
    .o_sid(sid)
  );
  // =====================================================================
  // Map build: clear on bus reset, record self-IDs, mark absent on done
  always_comb begin
    seen_nxt = seen_r;
    act_nxt = act_r;
    spd_nxt = spd_r;
    done_nxt = done_r;
    if (I_BUS_RESET) begin
      seen_nxt = '0;
      act_nxt = '0;
      spd_nxt = '0;
      done_nxt = 1'b0;
    end else begin
      if (I_SID_VALID && !done_r && (int'(sid.node) < NODES)) begin
        seen_nxt[sid.node] = 1'b1;
        act_nxt[sid.node] = 1'b1;
        spd_nxt[2*sid.node +: 2] = sid.speed;
      end
      if (I_SID_DONE && !done_r) begin
        done_nxt = 1'b1;
        for (int n = 0; n < NODES; n++) begin
          if (!seen_nxt[n]) begin
            spd_nxt[2*n +: 2] = `BTM_SPD_MISSING;
          end
        end
      end
    end
  end
  // Map registers
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      seen_r <= '0;
      act_r <= '0;
      spd_r <= '0;
      done_r <= 1'b0;
    end else if (I_CE) begin
      seen_r <= seen_nxt;
      act_r <= act_nxt;
      spd_r <= spd_nxt;
      done_r <= done_nxt;
    end
  end
  // =====================================================================
  // Own node forced present
  always_comb begin
    act_view = act_r;
    if (int'(I_OWN_NODE) < NODES) begin
      act_view[I_OWN_NODE] = 1'b1;
    end
  end
  // Word selection
  btm_rd_mux u_mux (
    .i_addr(I_ADDR),
    .i_act(act_view),
    .i_spd(spd_r),
    .o_data(mux_data)
  );
  // =====================================================================
  // Registered read answer, one cycle after the strobe
  always_comb begin
    rdata_nxt = rdata_r;
    rvalid_nxt = I_RD;
    if (I_RD) begin
      rdata_nxt = mux_data;
    end
  end
  // Read registers
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      rdata_r <= `BTM_RST_WORD;
      rvalid_r <= 1'b0;
    end else if (I_CE) begin
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end
  assign O_RDATA = rdata_r;
  assign O_RVALID = rvalid_r;
endmodule : btm_maps
`default_nettype wire

/* btm_map.svh */
// Purpose: Offsets, reset values and field positions of the topology maps
// Assumes: Host register address is a byte address, word aligned
// Notes: Included by the package and the design modules
`ifndef BTM_MAP_SVH
`define BTM_MAP_SVH
// =====================================================================
// Register offsets
`define BTM_OFS_ACT_LOW 8'hE8
`define BTM_OFS_ACT_HIGH 8'hEC
`define BTM_OFS_SPD_0 8'hF0
`define BTM_OFS_SPD_1 8'hF4
`define BTM_OFS_SPD_2 8'hF8
`define BTM_OFS_SPD_3 8'hFC
// =====================================================================
// Reset values and codes
`define BTM_RST_WORD 32'h0000_0000
`define BTM_RST_SPD 2'h0
`define BTM_SPD_MISSING 2'h3
`define BTM_NODE_COUNT 63
`define BTM_NODE_W 6
`define BTM_FIELDS_PER_WORD 16
// =====================================================================
// Self-ID packet fields
`define BTM_SID_PHY_MSB 29
`define BTM_SID_PHY_LSB 24
`define BTM_SID_SPD_MSB 15
`define BTM_SID_SPD_LSB 14
`endif

/* btm_pkg.sv */
// Purpose: Types shared by the topology map block
// Assumes: Constants come from btm_map.svh
// Notes: Only the speed code values are set here, the node width comes from the header
`include "btm_map.svh"
package btm_pkg;
  // ===================================================================
  // Speed codes
  typedef enum logic [1:0] {
    BTM_S100 = 2'h0,
    BTM_S200 = 2'h1,
    BTM_S400 = 2'h2,
    BTM_SRSV = 2'h3
  } btm_speed_e;
  // ===================================================================
  // One decoded self-ID entry
  typedef struct packed {
    logic [`BTM_NODE_W-1:0] node;
    logic [1:0] speed;
  } btm_sid_s;
endpackage : btm_pkg

/* btm_sid_decode.sv */
// Purpose: Pulls node number and speed code out of a self-ID quadlet
// Assumes: Quadlet is valid in the cycle of its strobe
// Notes: Only the first quadlet of each packet is presented here
`timescale 1ns/1ps
`default_nettype none
`include "btm_map.svh"
module btm_sid_decode (
  // Self-ID quadlet
  input wire logic [31:0] i_quad,
  // Decoded entry
  output var btm_pkg::btm_sid_s o_sid
);
  // =====================================================================
  // Field extraction
  always_comb begin
    o_sid.node = i_quad[`BTM_SID_PHY_MSB:`BTM_SID_PHY_LSB];
    o_sid.speed = i_quad[`BTM_SID_SPD_MSB:`BTM_SID_SPD_LSB];
  end
endmodule : btm_sid_decode
`default_nettype wire

/* btm_rd_mux.sv */
// Purpose: Selects the read word of the map registers by address
// Assumes: Maps are held flat, node 0 at index 0
// Notes: Unmapped addresses read zero
`timescale 1ns/1ps
`default_nettype none
`include "btm_map.svh"
module btm_rd_mux (
  // Address and maps
  input wire logic [7:0] i_addr,
  input wire logic [`BTM_NODE_COUNT-1:0] i_act,
  input wire logic [2*`BTM_NODE_COUNT-1:0] i_spd,
  // Read word
  output logic [31:0] o_data
);
  logic [31:0] act_lo;
  logic [31:0] act_hi;
  logic [31:0] spd_w [4];
  // =====================================================================
  // Word packing, lowest node in the upper bits
  genvar g;
  generate
    for (g = 0; g < 64; g++) begin : g_node
      if (g < 32) begin : g_lo
        assign act_lo[31-g] = i_act[g];
      end else if (g < `BTM_NODE_COUNT) begin : g_hi
        assign act_hi[63-g] = i_act[g];
      end else begin : g_pad
        assign act_hi[0] = 1'b0;
      end
      if (g < `BTM_NODE_COUNT) begin : g_spd
        assign spd_w[g/16][31-2*(g%16) -: 2] = i_spd[2*g +: 2];
      end else begin : g_spad
        assign spd_w[3][1:0] = 2'h0;
      end
    end
  endgenerate
  // Address decode
  always_comb begin
    if (i_addr == `BTM_OFS_ACT_LOW) begin
      o_data = act_lo;
    end else if (i_addr == `BTM_OFS_ACT_HIGH) begin
      o_data = act_hi;
    end else if (i_addr == `BTM_OFS_SPD_0) begin
      o_data = spd_w[0];
    end else if (i_addr == `BTM_OFS_SPD_1) begin
      o_data = spd_w[1];
    end else if (i_addr == `BTM_OFS_SPD_2) begin
      o_data = spd_w[2];
    end else if (i_addr == `BTM_OFS_SPD_3) begin
      o_data = spd_w[3];
    end else begin
      o_data = 32'h0000_0000;
    end
  end
endmodule : btm_rd_mux
`default_nettype wire

/* btm_maps_properties.sv */
// Purpose: Port checks of the topology map block
// Assumes: I_CE held high by the bench
// Notes: Bound to btm_maps below
`timescale 1ns/1ps
`default_nettype none
module btm_maps_chk (
  // Watched ports
  input wire logic I_CLK, I_RST_B, I_CE, I_BUS_RESET, I_SID_DONE,
  input wire logic I_SID_VALID, I_RD, O_RVALID,
  input wire logic [5:0] I_OWN_NODE,
  input wire logic [7:0] I_ADDR,
  input wire logic [31:0] I_SID_QUAD, O_RDATA
);
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RST_B);
  // ==================================================================
  // Read after a bus reset, no packet between
  sequence clr_rd;
    I_BUS_RESET ##1 !I_SID_VALID ##1 (I_RD && I_ADDR == 8'hF0 && !I_SID_VALID);
  endsequence
  // ==================================================================
  // Read port and map layout
  rvalid_pulse_a: assert property (I_RD |=> O_RVALID) else $error("read valid missing");
  rvalid_cause_a: assert property (O_RVALID |-> $past(I_RD)) else $error("stray read valid");
  data_hold_a: assert property (!I_RD |=> $stable(O_RDATA)) else $error("read data moved");
  own_bit_a: assert property (I_RD && I_ADDR == 8'hE8 && I_OWN_NODE < 6'h20
    |=> O_RDATA[31 - $past(I_OWN_NODE)]) else $error("own node bit clear");
  high_bit0_a: assert property (I_RD && I_ADDR == 8'hEC |=> !O_RDATA[0])
    else $error("unused active bit set");
  last_field_a: assert property (I_RD && I_ADDR == 8'hFC |=> O_RDATA[1:0] == 2'h0)
    else $error("unused speed field set");
  unmapped_zero_a: assert property (I_RD && I_ADDR < 8'hE8 |=> O_RDATA == 32'h0)
    else $error("unmapped read not zero");
  speed_clear_a: assert property (clr_rd |=> O_RDATA == 32'h0)
    else $error("speed map not cleared");
endmodule : btm_maps_chk
bind btm_maps btm_maps_chk i_btm_maps_chk (.I_CLK(I_CLK), .I_RST_B(I_RST_B), .I_CE(I_CE),
  .I_BUS_RESET(I_BUS_RESET), .I_SID_DONE(I_SID_DONE), .I_SID_VALID(I_SID_VALID),
  .I_RD(I_RD), .O_RVALID(O_RVALID), .I_OWN_NODE(I_OWN_NODE), .I_ADDR(I_ADDR),
  .I_SID_QUAD(I_SID_QUAD), .O_RDATA(O_RDATA));
`default_nettype wire

/* btm_sid_src.sv */
// Purpose: Self-ID packet source on the PHY side
// Assumes: One strobe per packet, first quadlet only
// Notes: Quadlet turns to its inverse after each strobe
`timescale 1ns/1ps
`default_nettype none
module btm_sid_src (
  // Clock
  input wire logic i_clk,
  // Self-ID quadlets
  output logic o_valid,
  output logic [31:0] o_quad
);
  initial begin
    o_valid = 1'b0;
    o_quad = 32'h0;
  end
  // ==================================================================
  // Sends one packet, then idles gap cycles
  task automatic send(input logic [5:0] node, input logic [1:0] spd, input int gap);
    @(posedge i_clk);
    o_valid <= 1'b1;
    o_quad <= {2'h2, node, 8'h00, spd, 14'h0000};
    @(posedge i_clk);
    o_valid <= 1'b0;
    o_quad <= ~{2'h2, node, 8'h00, spd, 14'h0000};
    repeat (gap) @(posedge i_clk);
  endtask : send
endmodule : btm_sid_src
`default_nettype wire

/* tb_top.sv */
// Purpose: Self-checking bench of the topology map block
// Assumes: Clock enable held high
// Notes: Expected maps kept in exp_act and exp_spd
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_mismatch++; \
  $display("wrong value at %0t got %h exp %h", $time, a, e); end end
module tb_top;
  logic clk, rst_b, bus_rst, done, rd, sid_v, rvalid;
  logic [5:0] own;
  logic [7:0] addr;
  logic [31:0] quad, rdata;
  logic exp_act [63];
  logic [1:0] exp_spd [63];
  logic seen [63];
  int n_mismatch = 0;
  int n_tests = 0;
  // ==================================================================
  // Clock, watchdog, instances
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    #400000;
    n_mismatch++;
    results();
  end
  btm_sid_src i_btm_sid_src (.i_clk(clk), .o_valid(sid_v), .o_quad(quad));
  btm_maps i_btm_maps (.I_CLK(clk), .I_RST_B(rst_b), .I_CE(1'b1), .I_BUS_RESET(bus_rst),
    .I_SID_DONE(done), .I_OWN_NODE(own), .I_SID_VALID(sid_v), .I_SID_QUAD(quad),
    .I_RD(rd), .I_ADDR(addr), .O_RDATA(rdata), .O_RVALID(rvalid));
  // ==================================================================
  // Expected map model
  function automatic logic [31:0] ew(input logic [7:0] a);
    ew = 32'h0;
    for (int n = 0; n < 63; n++) begin
      if (a == 8'hE8 && n < 32) ew[31 - n] = exp_act[n] | (own == n);
      if (a == 8'hEC && n > 31) ew[63 - n] = exp_act[n] | (own == n);
      if (a >= 8'hF0 && (a - 8'hF0) / 4 == n / 16) ew[31 - 2 * (n % 16) -: 2] = exp_spd[n];
    end
  endfunction : ew
  task automatic rd_chk(input logic [7:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(rvalid, 1'b1)
    `CHK(rdata, ew(a))
  endtask : rd_chk
  task automatic read_all();
    for (int a = 8'hE8; a <= 8'hFC; a += 4) rd_chk(8'(a));
    rd_chk(8'h00);
  endtask : read_all
  task automatic bus_reset();
    @(posedge clk);
    bus_rst <= 1'b1;
    @(posedge clk);
    bus_rst <= 1'b0;
    foreach (seen[n]) {seen[n], exp_act[n], exp_spd[n]} = 4'h0;
  endtask : bus_reset
  task automatic sid_end();
    @(posedge clk);
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
    foreach (seen[n]) if (!seen[n]) exp_spd[n] = 2'h3;
  endtask : sid_end
  task automatic add(input logic [5:0] n, input logic [1:0] s, input int gap);
    i_btm_sid_src.send(n, s, gap);
    if (n < 6'h3F) {seen[n], exp_act[n], exp_spd[n]} = {2'h3, s};
  endtask : add
  // ==================================================================
  // Scenarios
  task automatic t_reset_values();
    read_all();
  endtask : t_reset_values
  task automatic t_build();
    own <= 6'h28;
    bus_reset();
    add(6'h00, 2'h0, 0);
    add(6'h05, 2'h2, 0);
    add(6'h1F, 2'h1, 3);
    add(6'h20, 2'h2, 0);
    add(6'h3E, 2'h1, 0);
    add(6'h3F, 2'h2, 0);
    sid_end();
    i_btm_sid_src.send(6'h09, 2'h2, 0);
    read_all();
  endtask : t_build
  task automatic t_rebuild();
    own <= 6'h0A;
    bus_reset();
    rd_chk(8'hF0);
    add(6'h07, 2'h1, 0);
    add(6'h07, 2'h2, 0);
    sid_end();
    read_all();
  endtask : t_rebuild
  task automatic results();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results
  // ==================================================================
  // Main sequence
  initial begin
    {rst_b, bus_rst, done, rd, addr, own} = {4'h0, 8'h00, 6'h3F};
    foreach (seen[n]) {seen[n], exp_act[n], exp_spd[n]} = 4'h0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    t_reset_values();
    t_build();
    t_rebuild();
    results();
  end
endmodule : tb_top
`default_nettype wire
